/* File: core/pbus_host.sv */
// Host controller that drives a peripheral over the 8-bit parallel strobe bus
// Functional notes
// - Select envelopes every read or write strobe
// - Write data valid before strobe, held after
// - Reset held low at least 100 us
// - Select registered from the access state, not decoded from the address bus
// - Strobes may be memory or port pair
`timescale 1ns/1ps
`default_nettype none
`include "pbus_host_map.svh"

module pbus_host #(
	parameter int unsigned RESET_HOLD = `RESET_HOLD_CYCLES // Bus reset hold in cycles
) (
	input wire logic clock, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic req_valid, // Access request
	output logic req_ready, // Request accepted this cycle
	input wire logic req_write, // 1 write, 0 read
	input wire logic req_space, // 0 memory strobes, 1 port strobes
	input wire logic [`ADDR_W-1:0] req_addr, // Device register address
	input wire logic [`DATA_W-1:0] req_wdata, // Write data
	output logic resp_valid, // Access finished pulse
	output logic [`DATA_W-1:0] resp_rdata, // Read data
	input wire logic bus_reset_req, // Request to reset the device
	output logic bus_reset_n, // Device reset, active low
	output logic chip_select_n, // Device select, active low
	output logic memory_fetch_strobe_n, // Memory read strobe
	output logic memory_store_strobe_n, // Memory write strobe
	output logic port_fetch_strobe_n, // Port read strobe
	output logic port_store_strobe_n, // Port write strobe
	output logic [`ADDR_W-1:0] addr_out, // Address to device
	input wire logic [`DATA_W-1:0] data_lines_in, // Data bus sampled level
	output logic [`DATA_W-1:0] data_lines_out, // Data bus drive value
	output logic data_lines_oe_n, // Data bus drive enable, low drives
	input wire logic addr_buffer_direction, // Device address buffer direction
	input wire logic addr_buffer_output_enable, // Device address buffer enable
	output logic addr_bus_released // Host floats its address, device masters
);
	pbus_host_pkg::state_e state_reg, state_next;
	logic [`CNT_W-1:0] cnt_reg, cnt_next;
	logic write_reg, write_next;
	logic space_reg, space_next;
	logic [`ADDR_W-1:0] addr_reg, addr_next;
	logic [`DATA_W-1:0] wdata_reg, wdata_next;
	logic [`DATA_W-1:0] rdata_reg, rdata_next;
	logic resp_reg, resp_next;
	logic dma_own;

	localparam logic [`CNT_W-1:0] RESET_LAST = `CNT_W'(RESET_HOLD - 1);
	localparam logic [`CNT_W-1:0] SETUP_LAST = `CNT_W'(`SETUP_CYCLES - 1);
	localparam logic [`CNT_W-1:0] STROBE_LAST = `CNT_W'(`STROBE_CYCLES - 1);
	localparam logic [`CNT_W-1:0] HOLD_LAST = `CNT_W'(`HOLD_CYCLES - 1);

	// Device asserts buffer enable with direction out while it masters the address
	assign dma_own = addr_buffer_output_enable & addr_buffer_direction;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		write_next = write_reg;
		space_next = space_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		resp_next = 1'b0;
		unique case (state_reg)
			pbus_host_pkg::ST_RESET: begin
				// Hold bus reset for the minimum time
				if (cnt_reg >= RESET_LAST && !bus_reset_req) begin
					state_next = pbus_host_pkg::ST_IDLE;
					cnt_next = `RESET_CNT_ZERO;
				end else if (cnt_reg < RESET_LAST) begin
					cnt_next = cnt_reg + `CNT_W'(1);
				end
			end
			pbus_host_pkg::ST_IDLE: begin
				if (bus_reset_req) begin
					state_next = pbus_host_pkg::ST_RESET;
					cnt_next = `RESET_CNT_ZERO;
				end else if (req_valid && !dma_own) begin
					state_next = pbus_host_pkg::ST_SETUP;
					cnt_next = `RESET_CNT_ZERO;
					write_next = req_write;
					space_next = req_space;
					addr_next = req_addr;
					wdata_next = req_wdata;
				end
			end
			pbus_host_pkg::ST_SETUP: begin
				if (cnt_reg == SETUP_LAST) begin
					state_next = pbus_host_pkg::ST_STROBE;
					cnt_next = `RESET_CNT_ZERO;
				end else begin
					cnt_next = cnt_reg + `CNT_W'(1);
				end
			end
			pbus_host_pkg::ST_STROBE: begin
				if (cnt_reg == STROBE_LAST) begin
					state_next = pbus_host_pkg::ST_HOLD;
					cnt_next = `RESET_CNT_ZERO;
					// Sample read data just before the strobe rises
					if (!write_reg) begin
						rdata_next = data_lines_in;
					end
				end else begin
					cnt_next = cnt_reg + `CNT_W'(1);
				end
			end
			pbus_host_pkg::ST_HOLD: begin
				if (cnt_reg == HOLD_LAST) begin
					state_next = pbus_host_pkg::ST_DONE;
					cnt_next = `RESET_CNT_ZERO;
				end else begin
					cnt_next = cnt_reg + `CNT_W'(1);
				end
			end
			pbus_host_pkg::ST_DONE: begin
				state_next = pbus_host_pkg::ST_IDLE;
				resp_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= pbus_host_pkg::ST_RESET;
			cnt_reg <= `RESET_CNT_ZERO;
			write_reg <= 1'b0;
			space_reg <= 1'b0;
			addr_reg <= '0;
			wdata_reg <= '0;
			rdata_reg <= '0;
			resp_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			write_reg <= write_next;
			space_reg <= space_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			resp_reg <= resp_next;
		end
	end

	// Pins to the device leave flip-flops so select and strobes never glitch
	logic bus_reset_n_reg, bus_reset_n_next;
	logic select_n_reg, select_n_next;
	logic [3:0] strobes_n_reg, strobes_n_next;
	logic drive_n_reg, drive_n_next;

	// True while select must be held low around the strobe
	function automatic logic in_access_phase(input pbus_host_pkg::state_e st);
		return (st == pbus_host_pkg::ST_SETUP) || (st == pbus_host_pkg::ST_STROBE) ||
			(st == pbus_host_pkg::ST_HOLD);
	endfunction : in_access_phase

	// Active-low strobes ordered memory fetch, memory store, port fetch, port store
	function automatic logic [3:0] strobe_pattern_n(
		input logic strobe,
		input logic write,
		input logic space
	);
		logic [3:0] one_hot;
		one_hot = strobe ? (4'h8 >> {space, write}) : 4'h0;
		return ~one_hot;
	endfunction : strobe_pattern_n

	always_comb begin
		bus_reset_n_next = (state_next != pbus_host_pkg::ST_RESET);
		select_n_next = !in_access_phase(state_next);
		strobes_n_next = strobe_pattern_n(state_next == pbus_host_pkg::ST_STROBE, write_next,
			space_next);
		drive_n_next = !(in_access_phase(state_next) && write_next);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bus_reset_n_reg <= 1'b0;
			select_n_reg <= 1'b1;
			strobes_n_reg <= 4'hF;
			drive_n_reg <= 1'b1;
		end else begin
			bus_reset_n_reg <= bus_reset_n_next;
			select_n_reg <= select_n_next;
			strobes_n_reg <= strobes_n_next;
			drive_n_reg <= drive_n_next;
		end
	end

	assign req_ready = (state_reg == pbus_host_pkg::ST_IDLE) && !bus_reset_req && !dma_own;
	assign resp_valid = resp_reg;
	assign resp_rdata = rdata_reg;
	assign bus_reset_n = bus_reset_n_reg;
	// Select is a steady level that opens before and closes after the strobe
	assign chip_select_n = select_n_reg;
	assign memory_fetch_strobe_n = strobes_n_reg[3];
	assign memory_store_strobe_n = strobes_n_reg[2];
	assign port_fetch_strobe_n = strobes_n_reg[1];
	assign port_store_strobe_n = strobes_n_reg[0];
	assign addr_out = addr_reg;
	assign addr_bus_released = dma_own;
	// Write data driven for the whole select window, covering both strobe edges
	assign data_lines_out = wdata_reg;
	assign data_lines_oe_n = drive_n_reg;
endmodule : pbus_host
`default_nettype wire

/* File: core/pbus_host_map.svh */
// Constants for the parallel peripheral bus host controller
`ifndef PBUS_HOST_MAP_SVH
`define PBUS_HOST_MAP_SVH

`define DATA_W 8
`define ADDR_W 16
`define CLK_PERIOD_NS 10
// Reset hold time in microseconds and derived cycle count
`define RESET_HOLD_US 100
`define RESET_HOLD_CYCLES ((`RESET_HOLD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Phase lengths in cycles: select setup, strobe width, strobe hold under select
`define SETUP_CYCLES 2
`define STROBE_CYCLES 4
`define HOLD_CYCLES 2
`define CNT_W 14
`define RESET_CNT_ZERO 14'h0000

`endif

/* File: core/pbus_host_pkg.sv */
// Types for the parallel peripheral bus host controller
package pbus_host_pkg;
	typedef enum logic [2:0] {
		ST_RESET,
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_DONE
	} state_e;
	typedef enum logic {
		SPACE_MEMORY,
		SPACE_PORT
	} space_e;
endpackage : pbus_host_pkg

/* File: sim/pbus_host_assertions.sv */
// Bus protocol checker for the host controller
`timescale 1ns/1ps
`default_nettype none
module pbus_host_assertions #(parameter int unsigned RESET_HOLD = 10000) (
	input wire logic clock, // Clock
	input wire logic rst_n, // Reset
	input wire logic bus_reset_n, // Device reset
	input wire logic chip_select_n, // Select
	input wire logic memory_fetch_strobe_n, // Read
	input wire logic memory_store_strobe_n, // Write
	input wire logic port_fetch_strobe_n, // Read
	input wire logic port_store_strobe_n, // Write
	input wire logic [15:0] addr_out, // Address
	input wire logic data_lines_oe_n // Drive
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [3:0] stb;
	logic [15:0] low_reg, low_next;
	assign stb = ~{memory_store_strobe_n, port_store_strobe_n,
		memory_fetch_strobe_n, port_fetch_strobe_n};
	// Counts cycles that device reset has been low since host reset release or since device reset last fell
	always_comb low_next = (bus_reset_n || !rst_n) ? 16'h0000 : low_reg + 16'h0001;
	always_ff @(posedge clock) low_reg <= low_next;
	AST_STB_IN_SEL: assert property ((|stb || $fell(|stb)) |-> !chip_select_n && $past(!chip_select_n))
		else $error("strobe outside select");
	AST_WDATA_HELD: assert property ((|stb[3:2] || $fell(|stb[3:2])) |-> !data_lines_oe_n && $past(!data_lines_oe_n))
		else $error("write data not held");
	AST_RST_HOLD: assert property ($rose(bus_reset_n) |-> low_reg >= RESET_HOLD)
		else $error("device reset too short");
	AST_ADDR_STABLE: assert property (!chip_select_n && $past(!chip_select_n) |-> $stable(addr_out))
		else $error("address moved under select");
	AST_ONE_PAIR: assert property ($countones(stb) <= 1)
		else $error("two strobes low");
endmodule : pbus_host_assertions
bind pbus_host pbus_host_assertions #(.RESET_HOLD(RESET_HOLD)) u_chk (.*);
`default_nettype wire

/* File: sim/pbus_device_model.sv */
// Behavioural peripheral on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module pbus_device_model (
	input wire logic reset_n, // Reset
	input wire logic cs_n, // Select
	input wire logic rd_n, // Either read strobe
	input wire logic wr_n, // Either write strobe
	input wire logic [3:0] addr, // Register index
	input wire logic [7:0] din, // Bus level, kept apart from dout
	output logic drive, // Drives the bus
	output logic [7:0] dout // Read value
);
	logic [7:0] mem [16];
	assign drive = reset_n && !cs_n && !rd_n;
	assign dout = mem[addr];
	always @(posedge wr_n or negedge reset_n)
		if (!reset_n) foreach (mem[i]) mem[i] = 8'h00;
		else if (!cs_n) mem[addr] = din;
endmodule : pbus_device_model
`default_nettype wire

/* File: sim/test_pbus_host.sv */
// Self-checking bench for the bus host
`timescale 1ns/1ps
`default_nettype none
`include "pbus_host_map.svh"
module test_pbus_host;
	logic clock, rst_n, req_valid, req_ready, req_write, req_space, resp_valid, bus_reset_req;
	logic bus_reset_n, chip_select_n, data_lines_oe_n, drive, dma, addr_bus_released;
	logic memory_fetch_strobe_n, memory_store_strobe_n, port_fetch_strobe_n, port_store_strobe_n;
	logic [15:0] req_addr, addr_out;
	logic [7:0] req_wdata, resp_rdata, data_lines_in, data_lines_out, dout;
	int err_count, tests_run, seed, k;
	int ref_mem [16];
	// Floating bus shows a changing pattern
	assign data_lines_in = !data_lines_oe_n ? data_lines_out : drive ? dout : {8{clock}} ^ 8'hA5;
	pbus_host #(.RESET_HOLD(4)) u_dut (.*, .addr_buffer_direction(dma),
		.addr_buffer_output_enable(dma));
	pbus_device_model u_dev (.reset_n(bus_reset_n), .cs_n(chip_select_n), .drive(drive),
		.rd_n(memory_fetch_strobe_n & port_fetch_strobe_n), .addr(addr_out[3:0]), .dout(dout),
		.wr_n(memory_store_strobe_n & port_store_strobe_n), .din(data_lines_in));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Pins seen during each access against the request that was taken
	always @(negedge clock) begin
		if (!chip_select_n) begin
			chk(8'(data_lines_oe_n), 8'(!req_write));
			chk(addr_out[15:8], req_addr[15:8]);
			chk(addr_out[7:0], req_addr[7:0]);
		end
		if (!(memory_fetch_strobe_n & memory_store_strobe_n & port_fetch_strobe_n &
			port_store_strobe_n)) begin
			chk({4'h0, memory_fetch_strobe_n, memory_store_strobe_n, port_fetch_strobe_n,
				port_store_strobe_n}, {4'h0, ~{~req_space & ~req_write, ~req_space & req_write,
				req_space & ~req_write, req_space & req_write}});
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks=%0d mismatches=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	task automatic acc;
		{req_write, req_space, req_addr, req_wdata} = 26'($random(seed));
		req_valid = 1'b1;
		for (k = 0; req_ready !== 1'b1 && k < 50; k++) @(negedge clock);
		@(negedge clock);
		req_valid = 1'b0;
		for (k = 0; resp_valid !== 1'b1 && k < 20; k++) @(negedge clock);
		chk(8'(k), 8'(`SETUP_CYCLES + `STROBE_CYCLES + `HOLD_CYCLES + 1));
		if (req_write) ref_mem[req_addr[3:0]] = req_wdata;
		else chk(resp_rdata, 8'(ref_mem[req_addr[3:0]]));
	endtask : acc
	initial begin
		{rst_n, req_valid, req_write, req_space, bus_reset_req, dma} = 6'h00;
		{req_addr, req_wdata} = 24'h000000;
		seed = 27071;
		foreach (ref_mem[j]) ref_mem[j] = 0;
		repeat (6) @(negedge clock);
		chk(8'({bus_reset_n, chip_select_n, data_lines_oe_n}), 8'h03);
		rst_n = 1'b1;
		repeat (40) acc();
		$display("traffic test done");
		bus_reset_req = 1'b1;
		repeat (3) @(negedge clock);
		chk(8'({req_ready, bus_reset_n}), 8'h00);
		bus_reset_req = 1'b0;
		foreach (ref_mem[j]) ref_mem[j] = 0;
		repeat (20) acc();
		$display("device reset test done");
		dma = 1'b1;
		req_valid = 1'b1;
		@(negedge clock);
		chk(8'({req_ready, addr_bus_released}), 8'h01);
		repeat (3) @(negedge clock);
		chk(8'({chip_select_n, bus_reset_n}), 8'h03);
		{dma, req_valid} = 2'h0;
		$display("address release test done");
		end_of_test();
	end
	initial begin
		#100000;
		err_count++;
		end_of_test();
	end
endmodule : test_pbus_host
`default_nettype wire
